// file: src/nvm_pkg.sv
// constants and types shared by the nonvolatile memory access block
`default_nettype none
package nvm_pkg;
  // program space
  localparam int PROG_ADDR_W = 16;
  localparam int PROG_BYTES = 8192;
  localparam int PROG_IDX_W = 13;
  // data scratchpad: 160 pages of 4 bytes
  localparam int DATA_PAGES = 160;
  localparam logic [7:0] DATA_LAST_PAGE = 8'h9F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // flash command codes
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
  localparam logic [7:0] VERIFY_FAIL = 8'h01;
  // special function register addresses of the scratchpad and coefficients
  localparam logic [7:0] SFR_DATA1 = 8'hBC;
  localparam logic [7:0] SFR_DATA2 = 8'hBD;
  localparam logic [7:0] SFR_DATA3 = 8'hBE;
  localparam logic [7:0] SFR_DATA4 = 8'hBF;
  localparam logic [7:0] SFR_PAGE_ADDR = 8'hC6;
  localparam logic [7:0] SFR_COMMAND = 8'hB9;
  localparam logic [7:0] SFR_OFS_LOW = 8'hF1;
  localparam logic [7:0] SFR_OFS_HIGH = 8'hF2;
  localparam logic [7:0] SFR_GAIN_LOW = 8'hF3;
  localparam logic [7:0] SFR_GAIN_HIGH = 8'hF4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // parallel programming: port three opcodes
  localparam logic [7:0] PP_WRITE_PROG = 8'h01;
  localparam logic [7:0] PP_ERASE_PROG = 8'h02;
  localparam logic [7:0] PP_READ_PROG = 8'h03;
  // hidden calibration words, arbitrary factory defaults
  localparam logic [13:0] FACTORY_OFFSET = 14'h2000;
  localparam logic [13:0] FACTORY_GAIN = 14'h2000;
  // operation timing
  localparam int CLK_MHZ = 100;
  localparam int PROGRAM_US = 250;
  localparam int ERASE_US = 20000;
  localparam int PROGRAM_CYCLES = PROGRAM_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_US * CLK_MHZ;
  localparam int CNT_W = 22;
  localparam int CFG_STEPS = 4;
  typedef enum logic [1:0] {MODE_RUN, MODE_SERIAL, MODE_PARALLEL} mode_t;
endpackage
`default_nettype wire

// file: src/sfr_bus_if.sv
// special function register bus between core side and the flash block
`default_nettype none
interface sfr_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport master (output wr, rd, addr, wdata, input rdata, hit);
  modport slave (input wr, rd, addr, wdata, output rdata, hit);
endinterface
`default_nettype wire

// file: src/calib_regs.sv
// offset and gain calibration registers with power-up load
`default_nettype none
module calib_regs
  import nvm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  sfr_bus_if.slave bus,
  output logic [13:0] offset_coef,
  output logic [13:0] gain_coef
);
  import nvm_pkg::*;
  logic [5:0] offset_coef_high_reg, offset_coef_high_next;
  logic [7:0] offset_coef_low_reg, offset_coef_low_next;
  logic [5:0] gain_coef_high_reg, gain_coef_high_next;
  logic [7:0] gain_coef_low_reg, gain_coef_low_next;

  always_comb
  begin
    offset_coef_high_next = offset_coef_high_reg;
    offset_coef_low_next = offset_coef_low_reg;
    gain_coef_high_next = gain_coef_high_reg;
    gain_coef_low_next = gain_coef_low_reg;
    if (load)
    begin
      offset_coef_high_next = FACTORY_OFFSET[13:8];
      offset_coef_low_next = FACTORY_OFFSET[7:0];
      gain_coef_high_next = FACTORY_GAIN[13:8];
      gain_coef_low_next = FACTORY_GAIN[7:0];
    end
    else if (bus.wr)
    begin
      // user calibration overrides until next power-up
      case (bus.addr)
        SFR_OFS_HIGH: offset_coef_high_next = bus.wdata[5:0];
        SFR_OFS_LOW: offset_coef_low_next = bus.wdata;
        SFR_GAIN_HIGH: gain_coef_high_next = bus.wdata[5:0];
        SFR_GAIN_LOW: gain_coef_low_next = bus.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      offset_coef_high_reg <= 6'h00;
      offset_coef_low_reg <= 8'h00;
      gain_coef_high_reg <= 6'h00;
      gain_coef_low_reg <= 8'h00;
    end
    else
    begin
      offset_coef_high_reg <= offset_coef_high_next;
      offset_coef_low_reg <= offset_coef_low_next;
      gain_coef_high_reg <= gain_coef_high_next;
      gain_coef_low_reg <= gain_coef_low_next;
    end
  end

  always_comb
  begin
    bus.hit = 1'b1;
    bus.rdata = 8'h00;
    case (bus.addr)
      SFR_OFS_HIGH: bus.rdata = {2'b00, offset_coef_high_reg};
      SFR_OFS_LOW: bus.rdata = offset_coef_low_reg;
      SFR_GAIN_HIGH: bus.rdata = {2'b00, gain_coef_high_reg};
      SFR_GAIN_LOW: bus.rdata = gain_coef_low_reg;
      default: bus.hit = 1'b0;
    endcase
  end

  assign offset_coef = {offset_coef_high_reg, offset_coef_low_reg};
  assign gain_coef = {gain_coef_high_reg, gain_coef_low_reg};
endmodule // calib_regs
`default_nettype wire

// file: src/flash_program_and_calibration_load.sv
// program flash, data scratchpad and calibration load
`default_nettype none
module flash_program_and_calibration_load
  import nvm_pkg::*;
#(
  parameter int PROGRAM_CNT = PROGRAM_CYCLES,
  parameter int ERASE_CNT = ERASE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic download_strap_pin_n,
  input wire logic parallel_mode_pin,
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic port_zero_oe,
  input wire logic [7:0] port_one,
  input wire logic [4:0] port_two,
  input wire logic [7:0] port_three,
  input wire logic ale_write_strobe,
  input wire logic [nvm_pkg::PROG_ADDR_W-1:0] fetch_addr,
  output logic [7:0] fetch_data,
  output logic fetch_internal,
  input wire logic dl_wr,
  input wire logic [nvm_pkg::PROG_IDX_W-1:0] dl_addr,
  input wire logic [7:0] dl_data,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic core_stall,
  output logic cfg_done,
  output nvm_pkg::mode_t mode,
  output logic [13:0] offset_coef,
  output logic [13:0] gain_coef
);
  import nvm_pkg::*;

  // ***********************************************************
  // storage and state
  // ***********************************************************
  typedef enum {ST_CFG, ST_IDLE, ST_BUSY} state_t;
  logic [7:0] prog_mem_reg [PROG_BYTES];
  logic [7:0] data_mem_reg [DATA_PAGES*4];
  state_t state_reg, state_next;
  mode_t mode_reg, mode_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] page_reg, page_next;
  logic [7:0] edata_reg [4];
  logic [7:0] edata_next [4];
  logic [7:0] fetch_reg, p0_reg;
  logic [2:0] cfg_reg, cfg_next;
  logic strobe_d_reg;
  logic cal_load;
  logic page_ok;
  logic prog_wr;
  logic [PROG_IDX_W-1:0] prog_waddr;
  logic [7:0] prog_wdata;
  logic prog_erase;
  logic data_wr, data_erase_page, data_erase_all;
  logic [7:0] cal_rdata;
  logic cal_hit;

  sfr_bus_if cal_bus ();
  assign cal_bus.wr = sfr_wr && state_reg != ST_CFG;
  assign cal_bus.rd = sfr_rd;
  assign cal_bus.addr = sfr_addr;
  assign cal_bus.wdata = sfr_wdata;
  assign cal_rdata = cal_bus.rdata;
  assign cal_hit = cal_bus.hit;

  calib_regs u_calib (
    .clk(clk),
    .reset(reset),
    .load(cal_load),
    .bus(cal_bus),
    .offset_coef(offset_coef),
    .gain_coef(gain_coef)
  );

  function automatic logic [9:0] byte_index(input logic [7:0] page,
                                            input logic [1:0] lane);
    byte_index = {page, lane};
  endfunction

  assign page_ok = page_reg <= DATA_LAST_PAGE;

  // ***********************************************************
  // control: configuration, mode, data flash commands
  // ***********************************************************
  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    page_next = page_reg;
    cfg_next = cfg_reg;
    cal_load = 1'b0;
    data_wr = 1'b0;
    data_erase_page = 1'b0;
    data_erase_all = 1'b0;
    for (int i = 0; i < 4; i++)
      edata_next[i] = edata_reg[i];
    case (state_reg)
      ST_CFG:
      begin
        // power-up sequence copies hidden calibration words
        cfg_next = cfg_reg + 3'd1;
        if (cfg_reg == 3'(CFG_STEPS - 1))
        begin
          cal_load = 1'b1;
          state_next = ST_IDLE;
          if (parallel_mode_pin)
            mode_next = MODE_PARALLEL;
          else if (!download_strap_pin_n)
            mode_next = MODE_SERIAL;
          else
            mode_next = MODE_RUN;
        end
      end
      ST_IDLE:
      begin
        if (sfr_wr)
        begin
          case (sfr_addr)
            SFR_DATA1: edata_next[0] = sfr_wdata;
            SFR_DATA2: edata_next[1] = sfr_wdata;
            SFR_DATA3: edata_next[2] = sfr_wdata;
            SFR_DATA4: edata_next[3] = sfr_wdata;
            SFR_PAGE_ADDR: page_next = sfr_wdata;
            SFR_COMMAND:
            begin
              cmd_next = sfr_wdata;
              case (sfr_wdata)
                CMD_READ:
                begin
                  if (page_ok)
                    for (int i = 0; i < 4; i++)
                      edata_next[i] =
                        data_mem_reg[byte_index(page_reg, 2'(i))];
                  cmd_next = RESET_BYTE;
                end
                CMD_VERIFY:
                begin
                  cmd_next = RESET_BYTE;
                  for (int i = 0; i < 4; i++)
                    if (!page_ok || edata_reg[i] !=
                        data_mem_reg[byte_index(page_reg, 2'(i))])
                      cmd_next = VERIFY_FAIL;
                end
                CMD_PROGRAM:
                begin
                  state_next = ST_BUSY;
                  cnt_next = CNT_W'(PROGRAM_CNT - 1);
                end
                CMD_ERASE_PAGE, CMD_ERASE_ALL:
                begin
                  state_next = ST_BUSY;
                  cnt_next = CNT_W'(ERASE_CNT - 1);
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end
      end
      ST_BUSY:
      begin
        // core is held idle until the array operation completes
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == '0)
        begin
          state_next = ST_IDLE;
          cmd_next = RESET_BYTE;
          // array changes only at the end of the timed operation
          data_wr = cmd_reg == CMD_PROGRAM && page_ok;
          data_erase_page = cmd_reg == CMD_ERASE_PAGE && page_ok;
          data_erase_all = cmd_reg == CMD_ERASE_ALL;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= ST_CFG;
      mode_reg <= MODE_RUN;
      cnt_reg <= '0;
      cmd_reg <= RESET_BYTE;
      page_reg <= RESET_BYTE;
      cfg_reg <= 3'd0;
      for (int i = 0; i < 4; i++)
        edata_reg[i] <= RESET_BYTE;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      page_reg <= page_next;
      cfg_reg <= cfg_next;
      for (int i = 0; i < 4; i++)
        edata_reg[i] <= edata_next[i];
    end
  end

  // programming only clears bits: an unerased page keeps stale zeros
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (data_erase_all)
        for (int j = 0; j < DATA_PAGES; j++)
          data_mem_reg[byte_index(8'(j), 2'(i))] <= ERASED_BYTE;
      else if (data_erase_page)
        data_mem_reg[byte_index(page_reg, 2'(i))] <= ERASED_BYTE;
      else if (data_wr)
        data_mem_reg[byte_index(page_reg, 2'(i))] <=
          data_mem_reg[byte_index(page_reg, 2'(i))] & edata_reg[i];
    end
  end

  // ***********************************************************
  // program array loading
  // ***********************************************************
  always_comb
  begin
    prog_wr = 1'b0;
    prog_erase = 1'b0;
    prog_waddr = dl_addr;
    prog_wdata = dl_data;
    if (mode_reg == MODE_SERIAL && state_reg == ST_IDLE)
      prog_wr = dl_wr;
    else if (mode_reg == MODE_PARALLEL)
    begin
      // write happens on the rising edge of the strobe
      prog_waddr = {port_two, port_one};
      prog_wdata = port_zero_in;
      if (ale_write_strobe && !strobe_d_reg)
      begin
        prog_wr = port_three == PP_WRITE_PROG;
        prog_erase = port_three == PP_ERASE_PROG;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      strobe_d_reg <= 1'b0;
    else
      strobe_d_reg <= ale_write_strobe;
  end

  always_ff @(posedge clk)
  begin
    if (prog_erase)
    begin
      for (int i = 0; i < PROG_BYTES; i++)
        prog_mem_reg[i] <= ERASED_BYTE;
    end
    else if (prog_wr)
      prog_mem_reg[prog_waddr] <= prog_mem_reg[prog_waddr] & prog_wdata;
  end

  // ***********************************************************
  // read paths
  // ***********************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fetch_reg <= 8'h00;
      p0_reg <= 8'h00;
    end
    else
    begin
      fetch_reg <= prog_mem_reg[fetch_addr[PROG_IDX_W-1:0]];
      p0_reg <= prog_mem_reg[{port_two, port_one}];
    end
  end

  assign fetch_internal = fetch_addr < PROG_ADDR_W'(PROG_BYTES);
  assign fetch_data = fetch_reg;
  assign port_zero_out = p0_reg;
  assign port_zero_oe = mode_reg == MODE_PARALLEL &&
                        port_three == PP_READ_PROG;

  always_comb
  begin
    sfr_rdata = 8'h00;
    case (sfr_addr)
      SFR_DATA1: sfr_rdata = edata_reg[0];
      SFR_DATA2: sfr_rdata = edata_reg[1];
      SFR_DATA3: sfr_rdata = edata_reg[2];
      SFR_DATA4: sfr_rdata = edata_reg[3];
      SFR_PAGE_ADDR: sfr_rdata = page_reg;
      SFR_COMMAND: sfr_rdata = cmd_reg;
      default: if (cal_hit) sfr_rdata = cal_rdata;
    endcase
  end

  assign core_stall = state_reg != ST_IDLE;
  assign cfg_done = state_reg != ST_CFG;
  assign mode = mode_reg;
endmodule // flash_program_and_calibration_load
`default_nettype wire

// file: tb/flash_checker.sv
// port assertions for the flash and calibration block
`default_nettype none
module flash_checker
  import nvm_pkg::*;
#(
  parameter int PROGRAM_CNT = 20,
  parameter int ERASE_CNT = 50
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] port_three,
  input wire logic port_zero_oe,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_internal,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_stall,
  input wire logic cfg_done,
  input wire nvm_pkg::mode_t mode,
  input wire logic [13:0] offset_coef,
  input wire logic [13:0] gain_coef
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire [5:0] wd6 = sfr_wdata[5:0];
  // ****
  // command and coefficient writes
  // ****
  sequence cmd_w(logic [7:0] c);
    sfr_wr && !core_stall && sfr_addr == SFR_COMMAND && sfr_wdata == c;
  endsequence
  sequence coef_w(logic [7:0] a);
    cfg_done && sfr_wr && sfr_addr == a;
  endsequence
  map_low_a: assert property (
    fetch_internal == (fetch_addr < 16'h2000))
    else $error("program map wrong");
  cfg_time_a: assert property (
    $fell(reset) |-> ##[3:4] cfg_done)
    else $error("config too slow");
  factory_load_a: assert property (
    $rose(cfg_done) |-> offset_coef == FACTORY_OFFSET
      && gain_coef == FACTORY_GAIN)
    else $error("factory words not loaded");
  cfg_stall_a: assert property (
    !cfg_done |-> core_stall && mode == MODE_RUN)
    else $error("core runs during config");
  oe_read_a: assert property (
    port_zero_oe == (mode == MODE_PARALLEL && port_three == PP_READ_PROG))
    else $error("port zero drive wrong");
  ofs_write_a: assert property (
    coef_w(SFR_OFS_LOW) |=> offset_coef[7:0] == $past(sfr_wdata))
    else $error("offset low not written");
  gain_high_a: assert property (
    coef_w(SFR_GAIN_HIGH) |=> gain_coef[13:8] == $past(wd6))
    else $error("gain high not written");
  high_read_a: assert property (
    sfr_rd && sfr_addr == SFR_OFS_HIGH
      |-> sfr_rdata == {2'b00, offset_coef[13:8]})
    else $error("offset high read wrong");
  prog_stall_a: assert property (
    cmd_w(CMD_PROGRAM) |=> core_stall [*8])
    else $error("program does not stall");
  mode_hold_a: assert property (
    cfg_done && $past(cfg_done) |-> $stable(mode))
    else $error("mode changed");
endmodule // flash_checker

bind flash_program_and_calibration_load flash_checker #(
  .PROGRAM_CNT(PROGRAM_CNT), .ERASE_CNT(ERASE_CNT)) i_flash_checker (
  .clk(clk), .reset(reset), .port_three(port_three),
  .port_zero_oe(port_zero_oe), .fetch_addr(fetch_addr),
  .fetch_internal(fetch_internal), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .core_stall(core_stall), .cfg_done(cfg_done), .mode(mode),
  .offset_coef(offset_coef), .gain_coef(gain_coef));
`default_nettype wire

// file: tb/prog_host_model.sv
// parallel device programmer on the port pins
`default_nettype none
module prog_host_model
  import nvm_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] port_zero_out,
  input wire logic port_zero_oe,
  output logic [7:0] port_zero_in,
  output logic [7:0] port_one,
  output logic [4:0] port_two,
  output logic [7:0] port_three,
  output logic ale_write_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] host_d;
  // wire level: the device wins while it drives
  assign port_zero_in = port_zero_oe ? port_zero_out : host_d;
  initial
  begin
    host_d = 8'h00;
    {port_two, port_one} = 13'h0000;
    port_three = 8'h00;
    ale_write_strobe = 1'b0;
  end
  task automatic op(input logic [7:0] c, input logic [12:0] a,
    input logic [7:0] d);
    @(negedge clk);
    port_three = c;
    {port_two, port_one} = a;
    host_d = d;
    @(negedge clk);
    ale_write_strobe = 1'b1;
    @(negedge clk);
    ale_write_strobe = 1'b0;
    // released bus must not keep showing the data
    host_d = ~d;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(negedge clk);
    port_three = PP_READ_PROG;
    {port_two, port_one} = a;
    repeat (2) @(negedge clk);
    d = port_zero_in;
  endtask
endmodule // prog_host_model
`default_nettype wire

// file: tb/flash_program_and_calibration_load_test.sv
// self-checking bench for the flash and calibration block
`default_nettype none
module flash_program_and_calibration_load_test
  import nvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, strap_n, par_pin, p0_oe, ale, dl_wr, sfr_wr, sfr_rd;
  logic stall, done, internal;
  logic [7:0] p0_in, p0_out, p1, p3, sfr_addr, sfr_wdata, sfr_rdata;
  logic [7:0] dl_data, fetch_data, r, pg;
  logic [4:0] p2;
  logic [15:0] fetch_addr;
  logic [12:0] dl_addr, a;
  logic [13:0] ofs, gain;
  logic [31:0] seed, d, e;
  mode_t mode;
  int fails, n_compared, cyc;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  flash_program_and_calibration_load #(.PROGRAM_CNT(20), .ERASE_CNT(50))
    i_flash_program_and_calibration_load (
    .clk(clk), .reset(reset), .download_strap_pin_n(strap_n),
    .parallel_mode_pin(par_pin), .port_zero_in(p0_in),
    .port_zero_out(p0_out), .port_zero_oe(p0_oe), .port_one(p1),
    .port_two(p2), .port_three(p3), .ale_write_strobe(ale),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .fetch_internal(internal), .dl_wr(dl_wr), .dl_addr(dl_addr),
    .dl_data(dl_data), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .core_stall(stall), .cfg_done(done), .mode(mode),
    .offset_coef(ofs), .gain_coef(gain));
  prog_host_model i_prog_host_model (
    .clk(clk), .port_zero_out(p0_out), .port_zero_oe(p0_oe),
    .port_zero_in(p0_in), .port_one(p1), .port_two(p2),
    .port_three(p3), .ale_write_strobe(ale));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    @(negedge clk);
    sfr_addr = ad;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    @(negedge clk);
    sfr_addr = ad;
    sfr_rd = 1'b1;
    #2 v = sfr_rdata;
    @(negedge clk);
    sfr_rd = 1'b0;
  endtask
  // bounded wait while the core is held
  task automatic idle();
    int k;
    k = 0;
    @(negedge clk);
    while (stall !== 1'b0 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic boot(input logic s, input logic p);
    @(negedge clk);
    strap_n = s;
    par_pin = p;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    idle();
  endtask
  task automatic page_op(input logic [7:0] g, input logic [7:0] c,
    input logic [31:0] v);
    wr(SFR_PAGE_ADDR, g);
    for (int i = 0; i < 4; i++)
      wr(8'(SFR_DATA1 + i), v[8*i +: 8]);
    wr(SFR_COMMAND, c);
    idle();
  endtask
  task automatic page_chk(input logic [7:0] g, input logic [31:0] x);
    logic [7:0] v;
    page_op(g, CMD_READ, ~x);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(SFR_DATA1 + i), v);
      chk(v, x[8*i +: 8]);
    end
  endtask
  task automatic fetch_chk(input logic [15:0] fa, input logic [7:0] x);
    @(negedge clk);
    fetch_addr = fa;
    #1 chk(internal, fa < 16'h2000);
    @(negedge clk);
    if (fa < 16'h2000)
      chk(fetch_data, x);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  // ****
  // scenarios
  // ****
  initial
  begin
    reset = 1'b1;
    {strap_n, par_pin, dl_wr, sfr_wr, sfr_rd} = 5'b10000;
    {sfr_addr, sfr_wdata, dl_data, dl_addr} = '0;
    fetch_addr = 16'h0000;
    seed = 32'h99491B73;
    boot(1'b1, 1'b0);
    chk(mode, MODE_RUN);
    chk(ofs, FACTORY_OFFSET);
    chk(gain, FACTORY_GAIN);
    wr(SFR_OFS_HIGH, 8'hFF);
    rd(SFR_OFS_HIGH, r);
    chk(r, 8'h3F);
    d = rnd();
    wr(SFR_GAIN_LOW, d[7:0]);
    wr(SFR_GAIN_HIGH, d[15:8]);
    chk(gain, d[13:0]);
    e = rnd();
    wr(SFR_OFS_LOW, e[7:0]);
    chk(ofs, {6'h3F, e[7:0]});
    rd(8'hA5, r);
    chk(r, RESET_BYTE);
    page_op(8'h00, CMD_ERASE_ALL, 32'h0);
    // page beyond the last one can never verify
    page_op(8'hA0, CMD_VERIFY, 32'hFFFFFFFF);
    rd(SFR_COMMAND, r);
    chk(r, VERIFY_FAIL);
    for (int n = 0; n < 5; n++)
    begin
      pg = n == 0 ? 8'h00 : n == 1 ? DATA_LAST_PAGE : 8'(rnd() % 160);
      d = rnd();
      e = rnd();
      page_chk(pg, 32'hFFFFFFFF);
      page_op(pg, CMD_PROGRAM, d);
      page_chk(pg, d);
      page_op(pg, CMD_VERIFY, d);
      rd(SFR_COMMAND, r);
      chk(r, 8'h00);
      page_op(pg, CMD_VERIFY, d ^ {e[31:1], 1'b1});
      rd(SFR_COMMAND, r);
      chk(r, VERIFY_FAIL);
      page_op(pg, CMD_PROGRAM, e);
      page_chk(pg, d & e);
      page_op(pg, 8'h07, ~d);
      rd(SFR_COMMAND, r);
      chk(r, 8'h07);
      page_chk(pg, d & e);
      page_op(pg, n[0] ? CMD_ERASE_PAGE : CMD_ERASE_ALL, 32'h0);
      page_chk(pg, 32'hFFFFFFFF);
    end
    boot(1'b1, 1'b1);
    chk(mode, MODE_PARALLEL);
    i_prog_host_model.op(PP_ERASE_PROG, 13'h0000, 8'h00);
    idle();
    for (int n = 0; n < 4; n++)
    begin
      // random cells kept away from the serial download bytes
      a = n == 0 ? 13'h0000 : n == 1 ? 13'h1FFF : 13'h1000 | 13'(rnd());
      d = rnd();
      i_prog_host_model.op(PP_WRITE_PROG, a, d[7:0]);
      idle();
      i_prog_host_model.rd(a, r);
      chk(r, d[7:0]);
      fetch_chk({3'b000, a}, d[7:0]);
    end
    fetch_chk(16'h2000, 8'h00);
    fetch_chk(16'hFFFF, 8'h00);
    boot(1'b0, 1'b0);
    chk(mode, MODE_SERIAL);
    chk(ofs, FACTORY_OFFSET);
    d = rnd();
    @(negedge clk);
    {dl_wr, dl_addr, dl_data} = {1'b1, 13'h0800, d[7:0]};
    @(negedge clk);
    {dl_addr, dl_data} = {13'h0801, d[15:8]};
    @(negedge clk);
    dl_wr = 1'b0;
    fetch_chk(16'h0800, d[7:0]);
    fetch_chk(16'h0801, d[15:8]);
    stop_test();
  end
endmodule // flash_program_and_calibration_load_test
`default_nettype wire
